// *** src/pcs_defines.svh ***
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
// Register byte offsets
`define PCS_OFS_CTRL 4'h0
`define PCS_OFS_STAT 4'h4
`define PCS_OFS_MULT 4'h8
// Field positions
`define PCS_CTRL_AUTO 0
`define PCS_CTRL_MAN 1
`define PCS_STAT_SEL 0
`define PCS_STAT_LOCK 1
`define PCS_STAT_LOST 2
`define PCS_STAT_LOAD 3
`define PCS_MULT_M 16
// Reset values
`define PCS_RST_AUTO 1'b1
`define PCS_RST_CFG '0
// Counter limits
`define PCS_MAX_ODD 512
`define PCS_MAX_FAST 32
// Timing
`define PCS_CLK_MHZ 200
`define PCS_DLY_STEP_PS 250
`define PCS_DLY_SPAN_PS 3000
`define PCS_DLY_MAX (`PCS_DLY_SPAN_PS / `PCS_DLY_STEP_PS)
`define PCS_RELOCK_US 100
`define PCS_RELOCK_CYC (`PCS_RELOCK_US * `PCS_CLK_MHZ)
`define PCS_LOSS_NS 1280
`define PCS_LOSS_CYC (`PCS_LOSS_NS * `PCS_CLK_MHZ / 1000)
// Bus answers
`define PCS_RESP_OK 2'b00
`define PCS_RESP_ERR 2'b10
`endif

// *** src/pcs_pkg.sv ***
package pcs_pkg;
	// One post-scale output setting
	typedef struct packed {
		logic [4:0] dly;  // Signed delay steps
		logic [2:0] ph;   // Phase in eighths
		logic       half; // 50% duty
		logic [9:0] cnt;  // Count minus one
	} pcs_out_t;
	// Whole serial chain image
	typedef struct packed {
		pcs_out_t [5:0] o;
		logic [8:0]     m;
		logic [8:0]     n;
	} pcs_cfg_t;
	typedef enum logic [1:0] {SW_PRI = 2'b01, SW_SEC = 2'b10} pcs_sw_t;
	localparam int CFG_W = $bits(pcs_cfg_t);
endpackage : pcs_pkg

// *** src/pcs_chain.sv ***
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_chain
	import pcs_pkg::*;
#(
	parameter int W = CFG_W
) (
	input  wire logic         ref_clk_i, // System clock
	input  wire logic         rst_i,     // Sync reset
	input  wire logic         clr_i,     // Async chain clear
	input  wire logic         sclk_i,    // Shift clock pin
	input  wire logic         sdat_i,    // Shift data pin
	output logic [W-1:0]      chain_o,   // Chain contents
	output logic              load_o     // Last bit taken
);
	localparam int CW = $clog2(W + 1);
	typedef struct packed {
		logic [1:0]    ck;
		logic [1:0]    dt;
		logic          ck_d;
		logic [W-1:0]  sr;
		logic [CW-1:0] cnt;
		logic          ld;
	} pcs_chs_t;
	pcs_chs_t s;
	pcs_chs_t next_s;

	// Sample pins, shift on shift clock rise
	always_comb begin
		next_s = s;
		next_s.ld = 1'b0;
		next_s.ck = {s.ck[0], sclk_i};
		next_s.dt = {s.dt[0], sdat_i};
		next_s.ck_d = s.ck[1];
		if (s.ck[1] && !s.ck_d) begin
			next_s.sr = {s.sr[W-2:0], s.dt[1]};
			if (s.cnt == CW'(W - 1)) begin
				next_s.cnt = '0;
				next_s.ld = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 1'b1;
			end
		end
		if (rst_i) begin
			next_s = '0;
		end
	end

	// Clear acts without the clock
	always_ff @(posedge ref_clk_i or posedge clr_i) begin
		if (clr_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign chain_o = s.sr;
	assign load_o = s.ld;

	property p_shift;
		@(posedge ref_clk_i) disable iff (rst_i || clr_i)
		(s.ck[1] && !s.ck_d) |=> s.sr == {$past(s.sr[W-2:0]), $past(s.dt[1])};
	endproperty
	a_shift: assert property (p_shift) else $error("chain did not shift");

	property p_clr;
		@(posedge ref_clk_i) disable iff (rst_i)
		clr_i |-> (s.sr == '0 && s.cnt == '0 && !s.ld);
	endproperty
	a_clr: assert property (p_clr) else $error("chain not cleared");

	property p_last;
		@(posedge ref_clk_i) disable iff (rst_i || clr_i)
		s.ld |-> $past(s.cnt) == CW'(W - 1) && s.cnt == '0;
	endproperty
	a_last: assert property (p_last) else $error("load not on last bit");
endmodule : pcs_chain

// *** src/pcs_synth.sv ***
// Contract
// - Pre-scale and multiplier counters take settings 1 to 512.
// - Two regional, four global post-scale counters, each 1 to 512.
// - 50% duty counters reach 1024; other duty settings stop at 512.
// - Fast variant limits multiplier and post-scale counters to 32.
// - Oscillator is input times m over n; outputs divide it.
// - Phase steps are one eighth of the oscillator period.
// - Enhanced outputs carry a delay code, 250 ps steps, +-3 ns.
// - Six outputs enhanced; fast variant three, or two ports.
// - Two-port fast instances never drive global clock networks.
// - Single external output comes from first global post-scale counter; both fast variants hold ext_clk_o low instead.
// - Lost primary with automatic mode selects the secondary reference.
// - Reference change is glitch free; oscillator keeps running.
// - Lock returns within 100 microseconds after a switchover.
// - Chain is shifted serially on its own shift clock.
// - After the final bit the chain loads into settings at once.
// - Chain registers have an asynchronous clear.
// - Full reconfiguration at 25 MHz shift rate takes under 20 us.
// - Only counters and delays are reconfigurable; loop settings fixed.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_synth
	import pcs_pkg::*;
#(
	parameter int VARIANT    = 0,               // 0 enhanced, 1 fast, 2 fast two-port
	parameter int RELOCK_CYC = `PCS_RELOCK_CYC, // Relock wait in cycles
	parameter int LOSS_CYC   = `PCS_LOSS_CYC    // Missing-edge limit
) (
	input  wire logic        ref_clk_i,                   // 200 MHz clock
	input  wire logic        rst_i,                       // Sync reset
	input  wire logic        primary_reference_clock_i,   // Primary ref pin
	input  wire logic        secondary_reference_clock_i, // Secondary ref pin
	input  wire logic        man_switch_i,                // Manual switch pin
	input  wire logic        shift_clk_i,                 // Chain shift clock
	input  wire logic        shift_data_i,                // Chain shift data
	input  wire logic        chain_clr_i,                 // Async chain clear
	input  wire logic [3:0]  s_axi_awaddr_i,              // Write address
	input  wire logic        s_axi_awvalid_i,             // Write addr valid
	output logic             s_axi_awready_o,             // Write addr ready
	input  wire logic [31:0] s_axi_wdata_i,               // Write data
	input  wire logic [3:0]  s_axi_wstrb_i,               // Byte enables
	input  wire logic        s_axi_wvalid_i,              // Write data valid
	output logic             s_axi_wready_o,              // Write data ready
	output logic [1:0]       s_axi_bresp_o,               // Write response
	output logic             s_axi_bvalid_o,              // Response valid
	input  wire logic        s_axi_bready_i,              // Response ready
	input  wire logic [3:0]  s_axi_araddr_i,              // Read address
	input  wire logic        s_axi_arvalid_i,             // Read addr valid
	output logic             s_axi_arready_o,             // Read addr ready
	output logic [31:0]      s_axi_rdata_o,               // Read data
	output logic [1:0]       s_axi_rresp_o,               // Read response
	output logic             s_axi_rvalid_o,              // Read valid
	input  wire logic        s_axi_rready_i,              // Read ready
	output logic [5:0]       out_clk_o,                   // Post-scale outputs
	output logic             ext_clk_o,                   // External output
	output logic             gclk_route_o,                // Global net allowed
	output logic             ref_sel_o,                   // Secondary selected
	output logic             lock_o,                      // Lock indication
	output logic [29:0]      delay_code_o                 // Delay steps, 5 per output
);
	localparam int LW = $clog2(LOSS_CYC + 1);
	localparam int RW = $clog2(RELOCK_CYC + 1);
	localparam int NOUT = (VARIANT == 0) ? 6 : ((VARIANT == 1) ? 3 : 2);

	typedef struct packed {
		logic [1:0]       pr;
		logic [1:0]       sc;
		logic [1:0]       mw;
		logic             pr_d;
		logic             sc_d;
		logic             mw_d;
		pcs_sw_t          sw;
		logic [LW-1:0]    loss;
		logic             lost;
		logic [RW-1:0]    rl;
		logic             lock;
		logic             auto_en;
		logic             ld_flag;
		pcs_cfg_t         cfg;
		logic [15:0]      cr;
		logic             tick;
		logic [5:0][13:0] pos;
		logic [5:0]       ck;
		logic             ext;
		logic             route;
		logic [5:0][4:0]  dly;
		logic             aw_v;
		logic             w_v;
		logic [3:0]       awa;
		logic [31:0]      wd;
		logic [3:0]       ws;
		logic             awr;
		logic             wr;
		logic             bv;
		logic [1:0]       br;
		logic             arr;
		logic             rv;
		logic [1:0]       rr;
		logic [31:0]      rd;
	} pcs_st_t;

	pcs_st_t            s;
	pcs_st_t            next_s;
	logic [CFG_W-1:0]   chain_bits;
	logic               chain_load;
	logic               wr_go;
	logic               man_req;

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	// Pre-scale or multiplier count, 1..512, fast limit on request
	function automatic logic [9:0] nm_eff(input logic [8:0] v, input logic lim);
		logic [9:0] c;
		c = {1'b0, v} + 10'h001;
		if (lim && c > 10'(`PCS_MAX_FAST)) begin
			c = 10'(`PCS_MAX_FAST);
		end
		return c;
	endfunction : nm_eff

	// Post-scale count, 1024 only with 50% duty
	function automatic logic [10:0] eff_cnt(input pcs_out_t o);
		logic [10:0] c;
		c = {1'b0, o.cnt} + 11'h001;
		if (!o.half && c > 11'(`PCS_MAX_ODD)) begin
			c = 11'(`PCS_MAX_ODD);
		end
		if (VARIANT != 0 && c > 11'(`PCS_MAX_FAST)) begin
			c = 11'(`PCS_MAX_FAST);
		end
		return c;
	endfunction : eff_cnt

	// Output period in eighth-periods of the oscillator
	function automatic logic [13:0] per_of(input pcs_out_t o);
		return {eff_cnt(o), 3'b000};
	endfunction : per_of

	// Delay code limited to the +-3 ns span
	function automatic logic [4:0] dly_lim(input logic [4:0] d);
		logic [4:0] r;
		r = d;
		if ($signed(d) > $signed(5'(`PCS_DLY_MAX))) begin
			r = 5'(`PCS_DLY_MAX);
		end
		if ($signed(d) < -$signed(5'(`PCS_DLY_MAX))) begin
			r = -5'(`PCS_DLY_MAX);
		end
		return r;
	endfunction : dly_lim

	// Serial chain, loaded on its last bit; loop settings are not in it
	pcs_chain #(
		.W (CFG_W)
	) u_chain (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.clr_i     (chain_clr_i),
		.sclk_i    (shift_clk_i),
		.sdat_i    (shift_data_i),
		.chain_o   (chain_bits),
		.load_o    (chain_load)
	);

	// Write commits once both address and data are held
	assign wr_go = s.aw_v && s.w_v && !s.bv;
	// Manual switch from pin edge or control write
	assign man_req = (s.mw[1] && !s.mw_d)
		|| (wr_go && s.awa == `PCS_OFS_CTRL && s.ws[0] && s.wd[`PCS_CTRL_MAN]);

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		logic        pe;
		logic        se;
		logic        refe;
		logic        t;
		logic [15:0] n16;
		logic [15:0] add;
		logic [16:0] c17;
		logic [13:0] hi;
		logic [10:0] ec;
		pe = 1'b0;
		se = 1'b0;
		refe = 1'b0;
		t = 1'b0;
		n16 = '0;
		add = '0;
		c17 = '0;
		hi = '0;
		ec = '0;
		next_s = s;
		// Pin synchronisers and edge finders
		next_s.pr = {s.pr[0], primary_reference_clock_i};
		next_s.sc = {s.sc[0], secondary_reference_clock_i};
		next_s.mw = {s.mw[0], man_switch_i};
		next_s.pr_d = s.pr[1];
		next_s.sc_d = s.sc[1];
		next_s.mw_d = s.mw[1];
		pe = s.pr[1] && !s.pr_d;
		se = s.sc[1] && !s.sc_d;
		// Clock sense on the primary reference
		if (pe) begin
			next_s.loss = '0;
		end else if (s.loss != LW'(LOSS_CYC)) begin
			next_s.loss = s.loss + 1'b1;
		end
		next_s.lost = (next_s.loss == LW'(LOSS_CYC));
		// Reference select, sticky on secondary
		unique case (s.sw)
			SW_PRI: begin
				if (man_req || (s.auto_en && s.lost)) begin
					next_s.sw = SW_SEC;
				end
			end
			SW_SEC: begin
				if (man_req) begin
					next_s.sw = SW_PRI;
				end
			end
			default: next_s.sw = SW_PRI; // Illegal code falls back to primary
		endcase
		// Edges taken whole from one source only
		refe = (s.sw == SW_SEC) ? se : pe;
		// Relock countdown after a switch or reload
		if (next_s.sw != s.sw || chain_load) begin
			next_s.lock = 1'b0;
			next_s.rl = RW'(RELOCK_CYC - 1);
		end else if (s.rl != '0) begin
			next_s.rl = s.rl - 1'b1;
		end else begin
			next_s.lock = 1'b1;
		end
		// Settings change only with a full chain
		if (chain_load) begin
			next_s.cfg = pcs_cfg_t'(chain_bits);
		end
		// Oscillator: 8m added per ref edge, n taken per eighth-step out
		n16 = {6'h00, nm_eff(s.cfg.n, 1'b0)};
		if (refe) begin
			add = {3'h0, nm_eff(s.cfg.m, VARIANT != 0), 3'b000};
		end
		t = (s.cr >= n16);
		c17 = {1'b0, s.cr} + {1'b0, add};
		if (t) begin
			c17 = c17 - {1'b0, n16};
		end
		if (c17[16]) begin
			c17 = 17'h0ffff;
		end
		next_s.cr = c17[15:0];
		next_s.tick = t;
		// Post-scale counters, phase loaded at reconfiguration
		for (int i = 0; i < 6; i++) begin
			ec = eff_cnt(next_s.cfg.o[i]);
			if (next_s.cfg.o[i].half || ec == 11'h001) begin
				hi = {1'b0, ec, 2'b00};
			end else begin
				hi = 14'h0008;
			end
			if (chain_load) begin
				next_s.pos[i] = {11'h000, next_s.cfg.o[i].ph};
			end else if (t) begin
				if (s.pos[i] >= per_of(s.cfg.o[i]) - 14'h0001) begin
					next_s.pos[i] = '0;
				end else begin
					next_s.pos[i] = s.pos[i] + 14'h0001;
				end
			end
			next_s.ck[i] = (i < NOUT) && (next_s.pos[i] < hi);
			next_s.dly[i] = (VARIANT == 0) ? dly_lim(next_s.cfg.o[i].dly) : 5'h00;
		end
		next_s.ext = (VARIANT == 0) ? next_s.ck[2] : 1'b0;
		next_s.route = (VARIANT != 2);
		// AXI write: address and data in either order
		if (s.awr && s_axi_awvalid_i) begin
			next_s.aw_v = 1'b1;
			next_s.awa = s_axi_awaddr_i;
		end
		if (s.wr && s_axi_wvalid_i) begin
			next_s.w_v = 1'b1;
			next_s.wd = s_axi_wdata_i;
			next_s.ws = s_axi_wstrb_i;
		end
		if (s.bv && s_axi_bready_i) begin
			next_s.bv = 1'b0;
		end
		if (wr_go) begin
			next_s.aw_v = 1'b0;
			next_s.w_v = 1'b0;
			next_s.bv = 1'b1;
			next_s.br = `PCS_RESP_OK;
			unique case (s.awa)
				`PCS_OFS_CTRL: begin
					if (s.ws[0]) begin
						next_s.auto_en = s.wd[`PCS_CTRL_AUTO];
					end
				end
				`PCS_OFS_STAT: begin
					if (s.ws[0] && s.wd[`PCS_STAT_LOAD]) begin
						next_s.ld_flag = 1'b0;
					end
				end
				`PCS_OFS_MULT: begin
				end
				default: next_s.br = `PCS_RESP_ERR;
			endcase
		end
		// Reload flag: a new load wins over the clear
		if (chain_load) begin
			next_s.ld_flag = 1'b1;
		end
		// AXI read
		if (s.rv && s_axi_rready_i) begin
			next_s.rv = 1'b0;
		end
		if (s.arr && s_axi_arvalid_i) begin
			next_s.rv = 1'b1;
			next_s.rr = `PCS_RESP_OK;
			next_s.rd = '0;
			unique case (s_axi_araddr_i)
				`PCS_OFS_CTRL: next_s.rd[`PCS_CTRL_AUTO] = s.auto_en;
				`PCS_OFS_STAT: begin
					next_s.rd[`PCS_STAT_SEL] = s.sw[1];
					next_s.rd[`PCS_STAT_LOCK] = s.lock;
					next_s.rd[`PCS_STAT_LOST] = s.lost;
					next_s.rd[`PCS_STAT_LOAD] = s.ld_flag;
				end
				`PCS_OFS_MULT: begin
					next_s.rd[8:0] = s.cfg.n;
					next_s.rd[`PCS_MULT_M +: 9] = s.cfg.m;
				end
				default: next_s.rr = `PCS_RESP_ERR;
			endcase
		end
		next_s.awr = !next_s.aw_v;
		next_s.wr = !next_s.w_v;
		next_s.arr = !next_s.rv;
		if (rst_i) begin
			next_s = '0;
			next_s.sw = SW_PRI;
			next_s.auto_en = `PCS_RST_AUTO;
			next_s.cfg = `PCS_RST_CFG;
			next_s.rl = RW'(RELOCK_CYC - 1);
			next_s.route = (VARIANT != 2);
			next_s.awr = 1'b1;
			next_s.wr = 1'b1;
			next_s.arr = 1'b1;
		end
	end

	// State register
	always_ff @(posedge ref_clk_i) begin
		s <= next_s;
	end

	// Outputs straight from state
	assign s_axi_awready_o = s.awr;
	assign s_axi_wready_o = s.wr;
	assign s_axi_bresp_o = s.br;
	assign s_axi_bvalid_o = s.bv;
	assign s_axi_arready_o = s.arr;
	assign s_axi_rdata_o = s.rd;
	assign s_axi_rresp_o = s.rr;
	assign s_axi_rvalid_o = s.rv;
	assign out_clk_o = s.ck;
	assign ext_clk_o = s.ext;
	assign gclk_route_o = s.route;
	assign ref_sel_o = s.sw[1];
	assign lock_o = s.lock;
	assign delay_code_o = s.dly;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	localparam int DMAX = `PCS_DLY_MAX;

	property p_cfg_hold;
		@(posedge ref_clk_i) disable iff (rst_i)
		!chain_load |=> $stable(s.cfg);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("settings moved");

	property p_cfg_copy;
		@(posedge ref_clk_i) disable iff (rst_i)
		chain_load |=> s.cfg == $past(chain_bits) && s.ld_flag;
	endproperty
	a_cfg_copy: assert property (p_cfg_copy) else $error("chain not loaded");

	property p_auto;
		@(posedge ref_clk_i) disable iff (rst_i)
		(s.sw == SW_PRI && s.auto_en && s.lost) |=> s.sw == SW_SEC;
	endproperty
	a_auto: assert property (p_auto) else $error("no automatic switch");

	property p_hold_sec;
		@(posedge ref_clk_i) disable iff (rst_i)
		(s.sw == SW_SEC && !man_req) |=> s.sw == SW_SEC;
	endproperty
	a_hold_sec: assert property (p_hold_sec) else $error("left secondary");

	property p_relock;
		@(posedge ref_clk_i) disable iff (rst_i)
		$changed(s.sw) |-> !s.lock && s.rl == RW'(RELOCK_CYC - 1);
	endproperty
	a_relock: assert property (p_relock) else $error("relock wait wrong");

	property p_osc;
		@(posedge ref_clk_i) disable iff (rst_i)
		!chain_load ##1 !s.tick |-> $stable(s.pos);
	endproperty
	a_osc: assert property (p_osc) else $error("output moved between steps");

	property p_wrap;
		@(posedge ref_clk_i) disable iff (rst_i)
		(s.cr >= {6'h00, nm_eff(s.cfg.n, 1'b0)} && !chain_load
			&& s.pos[0] == per_of(s.cfg.o[0]) - 14'h0001)
			|=> s.pos[0] == 14'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("bad output period");

	property p_ext;
		@(posedge ref_clk_i) disable iff (rst_i)
		(VARIANT == 0) |-> ext_clk_o == out_clk_o[2];
	endproperty
	a_ext: assert property (p_ext) else $error("external output source");

	property p_route;
		@(posedge ref_clk_i) disable iff (rst_i)
		gclk_route_o == (VARIANT != 2);
	endproperty
	a_route: assert property (p_route) else $error("global route flag");

	property p_dly;
		@(posedge ref_clk_i) disable iff (rst_i)
		$signed(s.dly[0]) <= DMAX && $signed(s.dly[0]) >= -DMAX;
	endproperty
	a_dly: assert property (p_dly) else $error("delay out of span");
endmodule : pcs_synth

// *** verif/pcs_cfg_src.sv ***
`timescale 1ns/1ps
module pcs_cfg_src (
	input  wire logic         ref_clk_i, // System clock
	input  wire logic         go_i,      // Start a frame
	input  wire logic [7:0]   len_i,     // Bits in frame
	input  wire logic [131:0] frame_i,   // Frame, bit 0 sent last
	output logic              sclk_o,    // Shift clock
	output logic              sdat_o,    // Shift data
	output logic              busy_o     // Frame under way
);
	// ------
	// Frame engine
	// ------
	// Shift clock runs only inside a frame; data moves on its fall
	initial begin
		sclk_o = 1'b0;
		sdat_o = 1'b0;
		busy_o = 1'b0;
		forever begin
			@(posedge ref_clk_i);
			if (go_i === 1'b1) begin
				busy_o = 1'b1;
				#1;
				for (int i = int'(len_i) - 1; i >= 0; i--) begin
					sdat_o = frame_i[i];
					#80 sclk_o = 1'b1;
					#80 sclk_o = 1'b0;
				end
				busy_o = 1'b0;
			end else begin
				sdat_o <= ~sdat_o; // Idle line holds no value
			end
		end
	end
endmodule : pcs_cfg_src

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
	// ------
	// Signals
	// ------
	logic         ref_clk_i = 1'b0;
	logic         rst_i     = 1'b1;
	logic         pri       = 1'b0;
	logic         sec       = 1'b0;
	logic         pri_run   = 1'b1;
	logic         man_sw    = 1'b0;
	logic         clr       = 1'b1;
	logic         go        = 1'b0;
	logic [7:0]   len       = 8'h84;
	logic [131:0] frame     = '0;
	logic         awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [3:0]   awa = 4'h0, ara = 4'h0;
	logic [31:0]  wd  = 32'h0;
	logic         sclk, sdat, busy, awr, wr, bv, arr, rv, gclk, sel, lock, ext;
	logic [1:0]   br, rr;
	logic [31:0]  rd;
	logic [5:0]   oclk;
	logic [29:0]  dcode;
	int           n_mismatch = 0;
	int           n_checks   = 0;

	// System clock and two unrelated references
	always #2.5 ref_clk_i = ~ref_clk_i;
	always #80.3 pri = pri_run & ~pri;
	always #80.7 sec = ~sec;

	// ------
	// Instances
	// ------
	pcs_cfg_src src_u (
		.ref_clk_i(ref_clk_i), .go_i(go), .len_i(len), .frame_i(frame),
		.sclk_o(sclk), .sdat_o(sdat), .busy_o(busy)
	);
	pcs_synth #(.RELOCK_CYC(200), .LOSS_CYC(64)) dut_u (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .primary_reference_clock_i(pri),
		.secondary_reference_clock_i(sec), .man_switch_i(man_sw), .shift_clk_i(sclk),
		.shift_data_i(sdat), .chain_clr_i(clr), .s_axi_awaddr_i(awa),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
		.s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(rre), .out_clk_o(oclk), .ext_clk_o(ext), .gclk_route_o(gclk),
		.ref_sel_o(sel), .lock_o(lock), .delay_code_o(dcode)
	);

	// ------
	// Helpers
	// ------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : cyc

	// Wait for select (0) or lock (1) to reach v, at most n cycles
	task automatic wt(input int which, input logic v, input int n);
		for (int k = 0; k < n && (which ? lock : sel) !== v; k++) cyc(1);
	endtask : wt

	// Bus write, then the response code is compared
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		cyc(1);
		awa <= a;
		wd  <= d;
		awv <= 1'b1;
		wv  <= 1'b1;
		bre <= 1'b1;
		do begin
			cyc(1);
			if (awr === 1'b1) awv <= 1'b0;
			if (wr === 1'b1) wv <= 1'b0;
		end while (bv !== 1'b1);
		bre <= 1'b0;
		check(br, er);
	endtask : axw

	// Bus read, masked data and response compared
	task automatic axr(input logic [3:0] a, input logic [31:0] m, ed, input logic [1:0] er);
		cyc(1);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			cyc(1);
			if (arr === 1'b1) arv <= 1'b0;
		end while (rv !== 1'b1);
		rre <= 1'b0;
		check(rd & m, ed);
		check(rr, er);
	endtask : axr

	// One frame through the partner, then time for the load
	task automatic send(input logic [7:0] l, input logic [131:0] f);
		cyc(1);
		len   <= l;
		frame <= f;
		go    <= 1'b1;
		cyc(1);
		go    <= 1'b0;
		cyc(2);
		while (busy) cyc(1);
		cyc(8);
	endtask : send

	// ------
	// Scenarios
	// ------
	task automatic t_reset();
		axr(4'h0, 32'h3, 32'h1, 2'b00);
		axr(4'h4, 32'hd, 32'h0, 2'b00);
		axr(4'h8, '1, 32'h0, 2'b00);
		axr(4'hc, '1, 32'h0, 2'b10);
		axw(4'hc, 32'h2, 2'b10);
		axw(4'h8, 32'h00ff00ff, 2'b00);
		axr(4'h8, '1, 32'h0, 2'b00);
		check(sel, 1'b0);
		check(gclk, 1'b1);
		check(dcode, 30'h0);
	endtask : t_reset

	task automatic t_chain();
		logic [131:0] f;
		logic [5:0]   p;
		int           n0, n5, ne;
		f = '0;
		f[8:0]   = 9'h003;
		f[17:9]  = 9'h007;
		f[27:18] = 10'h001;
		f[28]    = 1'b1;
		f[36:32] = 5'h05;
		f[74:70] = 5'h1d;
		f[55:51] = 5'h0f;
		n0 = 0;
		n5 = 0;
		ne = 0;
		clr <= 1'b0;
		cyc(4);
		send(8'd100, '1);
		axr(4'h8, '1, 32'h0, 2'b00);
		check(dcode, 30'h0);
		clr <= 1'b1;
		cyc(2);
		clr <= 1'b0;
		cyc(4);
		send(8'd132, f);
		axr(4'h8, '1, 32'h00070003, 2'b00);
		axr(4'h4, 32'h8, 32'h8, 2'b00);
		axw(4'h4, 32'h8, 2'b00);
		axr(4'h4, 32'h8, 32'h0, 2'b00);
		check(dcode[4:0], 5'h05);
		check(dcode[14:10], 5'h1d);
		check(dcode[9:5], 5'h0c);
		// Rising edges over 3200 ns, oscillator at 12.5 MHz
		for (int k = 0; k < 640; k++) begin
			p = {oclk[5], ext, 3'h0, oclk[0]};
			cyc(1);
			n0 += int'(oclk[0] & ~p[0]);
			n5 += int'(oclk[5] & ~p[5]);
			ne += int'(ext & ~p[4]);
		end
		check(n0 inside {[18:22]}, 1'b1);
		check(n5 inside {[38:42]}, 1'b1);
		check(ne inside {[38:42]}, 1'b1);
	endtask : t_chain

	task automatic t_switch();
		wt(1, 1'b1, 300);
		check(lock, 1'b1);
		pri_run = 1'b0;
		wt(0, 1'b1, 150);
		check(sel, 1'b1);
		cyc(3);
		check(lock, 1'b0);
		wt(1, 1'b1, 230);
		check(lock, 1'b1);
		pri_run = 1'b1;
		cyc(200);
		check(sel, 1'b1);
		man_sw <= 1'b1;
		cyc(4);
		man_sw <= 1'b0;
		wt(0, 1'b0, 10);
		check(sel, 1'b0);
		axw(4'h0, 32'h3, 2'b00);
		wt(0, 1'b1, 10);
		check(sel, 1'b1);
		axr(4'h4, 32'h1, 32'h1, 2'b00);
		axw(4'h0, 32'h2, 2'b00);
		wt(0, 1'b0, 10);
		check(sel, 1'b0);
		pri_run = 1'b0;
		cyc(200);
		check(sel, 1'b0);
		axr(4'h4, 32'h4, 32'h4, 2'b00);
		pri_run = 1'b1;
	endtask : t_switch

	// ------
	// Sequence and watchdog
	// ------
	initial begin
		cyc(2);
		rst_i <= 1'b0;
		t_reset();
		t_chain();
		t_switch();
		close_out();
	end

	// Hang guard, well above the expected run
	initial begin
		#150us;
		n_mismatch++;
		close_out();
	end
endmodule : tb
